//--- rtl/icc_ctrl_top.sv
// module: register bank for integration, enables, alarms and transfers
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module icc_ctrl_top
	import icc_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RST_B_IN,
	// register bus write channels
	input wire logic [15:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	// register bus read channels
	input wire logic [15:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	// alarm events from core logic
	input wire logic OUT_BUS_CLK_LOSS_IN,
	input wire logic IN_BUS_CLK_LOSS_IN,
	input wire logic TX_BUS_FIFO_OVFL_IN,
	input wire logic TX_CELL_MEM_FULL_IN,
	// overflow status and gated interrupt pulses
	input wire logic [7:0] GROUP_OVFL_STATUS_IN,
	input wire logic [7:0] RX_FIFO_OVFL_STATUS_IN,
	output logic [7:0] GROUP_OVFL_IRQ_OUT,
	output logic [7:0] RX_FIFO_OVFL_IRQ_OUT,
	// integration period ticks per group
	output logic [7:0] INTEG_TICK_OUT,
	// counter access port
	output logic CNT_START_OUT,
	output logic [1:0] CNT_OP_OUT,
	output logic CNT_DIR_OUT,
	output logic CNT_IEN_VAL_OUT,
	input wire logic CNT_DONE_IN,
	// counter latching
	input wire logic COUNTER_LATCH_STROBE_IN,
	output logic COUNTER_LATCH_OUT
);
	// mapped index check, used for read and write
	function automatic logic idx_mapped(input logic [11:0] idx);
		if (idx >= IDX_INTEG_FIRST && idx <= IDX_INTEG_LAST) begin
			return 1'b1;
		end else if (idx == IDX_GRP_IRQ_EN || idx == IDX_RX_IRQ_EN) begin
			return 1'b1;
		end else if (idx == IDX_GEN_STATUS || idx == IDX_XFER_CMD) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// byte lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] strb);
		return {strb[1] ? new_v[15:8] : old_v[15:8],
			strb[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	// low-bit mask of one integration period
	function automatic logic [INTEG_CNT_W-1:0] period_mask(
		input logic [3:0] code);
		logic [4:0] sh;
		sh = 5'(code) + INTEG_BASE_EXP;
		return (22'h1 << sh) - 22'h1;
	endfunction

	logic aw_have_r;
	logic [11:0] aw_idx_r;
	logic w_have_r;
	logic [15:0] w_data_r;
	logic [1:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [15:0] integ_r [4];
	logic [7:0] grp_en_r;
	logic [7:0] rx_en_r;
	logic [3:0] sts_r;
	logic [15:0] cmd_r;
	logic toggle_r;
	logic done_r;
	icc_xfer_state_t xs_r;
	logic start_r;
	logic [7:0] grp_prev_r;
	logic [7:0] rx_prev_r;
	logic [7:0] grp_irq_r;
	logic [7:0] rx_irq_r;
	logic [INTEG_CNT_W-1:0] integ_cnt_r;
	logic [7:0] tick_r;
	logic [7:0] tick_nxt;
	logic [15:0] rd_word;
	icc_latch_if lif ();

	// write decode
	wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
	wire wr_ok = wr_fire && idx_mapped(aw_idx_r);
	wire [11:0] integ_sel = aw_idx_r - IDX_INTEG_FIRST;
	wire wr_integ = wr_ok && aw_idx_r <= IDX_INTEG_LAST
		&& aw_idx_r >= IDX_INTEG_FIRST;
	wire wr_grp_en = wr_ok && aw_idx_r == IDX_GRP_IRQ_EN;
	wire wr_rx_en = wr_ok && aw_idx_r == IDX_RX_IRQ_EN;
	wire wr_sts = wr_ok && aw_idx_r == IDX_GEN_STATUS;
	wire wr_cmd = wr_ok && aw_idx_r == IDX_XFER_CMD;
	wire [15:0] wv_cmd = merge16(cmd_r, w_data_r, w_strb_r);
	wire [15:0] wv_low = merge16(16'h0, w_data_r, w_strb_r);
	wire [15:0] wv_sts_full = merge16({12'h0, sts_r}, w_data_r, w_strb_r);
	wire [3:0] wv_sts = wv_sts_full[3:0];
	wire [1:0] new_op = wv_cmd[CMD_OP_LSB +: 2];
	wire [1:0] new_mode = wv_cmd[CMD_MODE_LSB +: 2];
	wire start_ok = wr_cmd && xs_r == XS_IDLE && new_op != OP_NONE;
	wire [11:0] ar_idx = S_AXI_ARADDR_IN[13:2];
	wire ar_fire = S_AXI_ARVALID_IN && !rvalid_r;

	// bus handshake outputs
	assign S_AXI_AWREADY_OUT = !aw_have_r;
	assign S_AXI_WREADY_OUT = !w_have_r;
	assign S_AXI_ARREADY_OUT = !rvalid_r;
	assign S_AXI_BVALID_OUT = bvalid_r;
	assign S_AXI_BRESP_OUT = bresp_r;
	assign S_AXI_RVALID_OUT = rvalid_r;
	assign S_AXI_RDATA_OUT = rdata_r;
	assign S_AXI_RRESP_OUT = rresp_r;

	// read data selection
	always_comb begin
		rd_word = 16'h0;
		if (ar_idx >= IDX_INTEG_FIRST && ar_idx <= IDX_INTEG_LAST) begin
			rd_word = integ_r[2'(ar_idx - IDX_INTEG_FIRST)];
		end else if (ar_idx == IDX_GRP_IRQ_EN) begin
			rd_word = {8'h0, grp_en_r};
		end else if (ar_idx == IDX_RX_IRQ_EN) begin
			rd_word = {8'h0, rx_en_r};
		end else if (ar_idx == IDX_GEN_STATUS) begin
			rd_word = {12'h0, sts_r};
		end else if (ar_idx == IDX_XFER_CMD) begin
			rd_word = {cmd_r[15:8], done_r, toggle_r, 1'b0,
				cmd_r[4:0]};
		end
	end

	// bus channel state
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			aw_have_r <= 1'b0;
			aw_idx_r <= '0;
			w_have_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_IN && !aw_have_r) begin
				aw_have_r <= 1'b1;
				aw_idx_r <= S_AXI_AWADDR_IN[13:2];
			end else if (wr_fire) begin
				aw_have_r <= 1'b0;
			end
			if (S_AXI_WVALID_IN && !w_have_r) begin
				w_have_r <= 1'b1;
				w_data_r <= S_AXI_WDATA_IN[15:0];
				w_strb_r <= S_AXI_WSTRB_IN[1:0];
			end else if (wr_fire) begin
				w_have_r <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BREADY_IN) begin
				bvalid_r <= 1'b0;
			end
			if (ar_fire) begin
				rvalid_r <= 1'b1;
				rdata_r <= {16'h0, rd_word};
				rresp_r <= idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RREADY_IN) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// software-written registers
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			for (int i = 0; i < 4; i++) begin
				integ_r[i] <= RST_INTEG;
			end
			grp_en_r <= RST_IRQ_EN[7:0];
			rx_en_r <= RST_IRQ_EN[7:0];
			cmd_r <= RST_XFER & MASK_XFER;
			toggle_r <= RST_XFER[CMD_TOGGLE];
		end else begin
			if (wr_integ) begin
				integ_r[integ_sel[1:0]] <= merge16(integ_r[integ_sel[1:0]],
					w_data_r, w_strb_r) & MASK_INTEG;
			end
			if (wr_grp_en) begin
				grp_en_r <= wv_low[7:0];
			end
			if (wr_rx_en) begin
				rx_en_r <= wv_low[7:0];
			end
			if (wr_cmd) begin
				cmd_r <= wv_cmd & MASK_XFER;
			end
			if (wr_fire) begin
				toggle_r <= ~toggle_r;
			end
		end
	end

	// latched alarms; an event in the clearing cycle wins
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			sts_r <= RST_STATUS[3:0];
		end else begin
			sts_r <= ((wr_sts ? wv_sts : sts_r) & sts_r)
				| {OUT_BUS_CLK_LOSS_IN, IN_BUS_CLK_LOSS_IN,
				TX_BUS_FIFO_OVFL_IN, TX_CELL_MEM_FULL_IN};
		end
	end

	// transfer sequencer
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			xs_r <= XS_IDLE;
			done_r <= RST_XFER[CMD_DONE];
			start_r <= 1'b0;
		end else begin
			start_r <= start_ok;
			case (xs_r)
				XS_IDLE: begin
					if (start_ok) begin
						xs_r <= XS_BUSY;
						done_r <= 1'b0;
					end
				end
				XS_BUSY: begin
					if (CNT_DONE_IN) begin
						xs_r <= XS_IDLE;
						done_r <= 1'b1;
					end
				end
				default: xs_r <= XS_IDLE;
			endcase
		end
	end
	assign CNT_START_OUT = start_r;
	assign CNT_OP_OUT = cmd_r[CMD_OP_LSB +: 2];
	assign CNT_DIR_OUT = cmd_r[CMD_DIR];
	assign CNT_IEN_VAL_OUT = cmd_r[CMD_IEN_VAL];

	// integration period ticks, two groups per register
	generate
		for (genvar g = 0; g < 8; g++) begin : g_tick
			wire [3:0] code = (g < 4) ? integ_r[g % 4][INTEG_LO_LSB +: 4]
				: integ_r[g % 4][INTEG_HI_LSB +: 4];
			assign tick_nxt[g] = code != INTEG_RSVD_CODE
				&& (integ_cnt_r & period_mask(code)) == '0;
		end
	endgenerate

	// interrupt gating and tick registers
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			integ_cnt_r <= '0;
			tick_r <= '0;
			grp_prev_r <= '0;
			rx_prev_r <= '0;
			grp_irq_r <= '0;
			rx_irq_r <= '0;
		end else begin
			integ_cnt_r <= integ_cnt_r + 22'h1;
			tick_r <= tick_nxt;
			grp_prev_r <= GROUP_OVFL_STATUS_IN;
			rx_prev_r <= RX_FIFO_OVFL_STATUS_IN;
			grp_irq_r <= GROUP_OVFL_STATUS_IN & ~grp_prev_r & grp_en_r;
			rx_irq_r <= RX_FIFO_OVFL_STATUS_IN & ~rx_prev_r & rx_en_r;
		end
	end
	assign INTEG_TICK_OUT = tick_r;
	assign GROUP_OVFL_IRQ_OUT = grp_irq_r;
	assign RX_FIFO_OVFL_IRQ_OUT = rx_irq_r;

	// latch source control; software trigger on bit 10 rising
	assign lif.mode = icc_latch_mode_t'(cmd_r[CMD_MODE_LSB +: 2]);
	// trigger only counts while software mode is already in force
	assign lif.sw_trig = wr_cmd && lif.mode == LM_SW && new_mode == LM_SW
		&& wv_cmd[CMD_SW_TRIG] && !cmd_r[CMD_SW_TRIG];
	assign COUNTER_LATCH_OUT = lif.latch_pulse;

	icc_latch_unit u_latch (
		.clk_in(REF_CLK_IN),
		.rst_b_in(RST_B_IN),
		.strobe_pin_in(COUNTER_LATCH_STROBE_IN),
		.lif(lif)
	);

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	AST_INTEG_RSVD: assert property ($past(integ_r[0][3:0]) == INTEG_RSVD_CODE
		|-> !INTEG_TICK_OUT[0])
		else $error("tick with reserved integration code");
	AST_INTEG_PERIOD: assert property (INTEG_TICK_OUT[4] |->
		($past(integ_cnt_r) & period_mask($past(integ_r[0][11:8]))) == '0)
		else $error("group tick off its period");
	AST_GRP_IRQ: assert property ($rose(GROUP_OVFL_STATUS_IN[0]) && grp_en_r[0]
		|=> GROUP_OVFL_IRQ_OUT[0])
		else $error("enabled group overflow gave no interrupt");
	AST_RX_MASK: assert property (!rx_en_r[2] |=> !RX_FIFO_OVFL_IRQ_OUT[2])
		else $error("masked fifo overflow raised interrupt");
	AST_STS_HOLD: assert property (sts_r[STS_OUT_CLK] && !wr_sts
		|=> sts_r[STS_OUT_CLK])
		else $error("clock loss alarm dropped without clear");
	AST_STS_SET: assert property (TX_CELL_MEM_FULL_IN |=> sts_r[STS_NO_CELL])
		else $error("no free cell alarm not latched");
	AST_SW_TRIG: assert property (lif.sw_trig |=> COUNTER_LATCH_OUT)
		else $error("software latch trigger lost");
	AST_DONE_DROP: assert property (CNT_START_OUT |-> !done_r
		&& xs_r == XS_BUSY)
		else $error("done not cleared on new transfer");
	AST_TOGGLE: assert property (wr_fire |=> toggle_r != $past(toggle_r))
		else $error("toggle bit did not invert");
	AST_CMD_DIR: assert property (CNT_START_OUT |->
		CNT_DIR_OUT == $past(wv_cmd[CMD_DIR]) && CNT_OP_OUT == $past(new_op)
		&& CNT_OP_OUT != OP_NONE)
		else $error("transfer started with bad command fields");
endmodule

//--- rtl/icc_latch_unit.sv
// module: counter latch pulse source from pin, divider or software
`timescale 1ns/100ps
module icc_latch_unit
	import icc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// latch strobe pin
	input wire logic strobe_pin_in,
	// control side
	icc_latch_if.unit lif
);
	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic [12:0] edge_cnt_r;
	logic pulse_r;
	wire rise = sync2_r & ~sync3_r;
	wire div_hit = rise && (edge_cnt_r == LATCH_EDGE_LAST);
	logic pulse_nxt;

	// choose the latch source
	always_comb begin
		case (lif.mode)
			LM_OFF: pulse_nxt = 1'b0;
			LM_EVERY: pulse_nxt = rise;
			LM_DIV: pulse_nxt = div_hit;
			LM_SW: pulse_nxt = lif.sw_trig;
			default: pulse_nxt = 1'b0;
		endcase
	end

	// pin synchroniser, edge divider and pulse
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			edge_cnt_r <= '0;
			pulse_r <= 1'b0;
		end else begin
			sync1_r <= strobe_pin_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			pulse_r <= pulse_nxt;
			if (lif.mode != LM_DIV || div_hit) begin
				edge_cnt_r <= '0;
			end else if (rise) begin
				edge_cnt_r <= edge_cnt_r + 13'h1;
			end
		end
	end
	assign lif.latch_pulse = pulse_r;

	AST_EVERY_EDGE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(lif.mode == LM_EVERY && rise) |=> pulse_r)
		else $error("edge mode missed a latch");
	AST_OFF_QUIET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(lif.mode == LM_OFF) |=> !pulse_r)
		else $error("latch pulse with latching off");
endmodule

//--- shared/icc_latch_if.sv
// interface: latch mode, software trigger and latch pulse
`timescale 1ns/100ps
interface icc_latch_if;
	import icc_pkg::*;
	icc_latch_mode_t mode;
	logic sw_trig;
	logic latch_pulse;
	modport ctl (output mode, output sw_trig, input latch_pulse);
	modport unit (input mode, input sw_trig, output latch_pulse);
endinterface

//--- shared/icc_pkg.sv
// package: constants and types for the counter and alarm control block
package icc_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_INTEG_FIRST = 12'h403;
	localparam logic [11:0] IDX_INTEG_LAST = 12'h406;
	localparam logic [11:0] IDX_GRP_IRQ_EN = 12'h40b;
	localparam logic [11:0] IDX_RX_IRQ_EN = 12'h40c;
	localparam logic [11:0] IDX_GEN_STATUS = 12'h40e;
	localparam logic [11:0] IDX_XFER_CMD = 12'h40f;
	// reset values
	localparam logic [15:0] RST_INTEG = 16'h0c0c;
	localparam logic [15:0] RST_IRQ_EN = 16'h0000;
	localparam logic [15:0] RST_STATUS = 16'h0000;
	localparam logic [15:0] RST_XFER = 16'h0800;
	// writable bit masks
	localparam logic [15:0] MASK_INTEG = 16'h0fff;
	localparam logic [15:0] MASK_XFER = 16'h0f1f;
	// integration fields
	localparam int INTEG_LO_LSB = 0;
	localparam int INTEG_HI_LSB = 8;
	localparam logic [3:0] INTEG_RSVD_CODE = 4'hf;
	localparam logic [4:0] INTEG_BASE_EXP = 5'h08;
	localparam int INTEG_CNT_W = 22;
	// general status fields
	localparam int STS_OUT_CLK = 3;
	localparam int STS_IN_CLK = 2;
	localparam int STS_TX_FIFO = 1;
	localparam int STS_NO_CELL = 0;
	// transfer command fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DIR = 2;
	localparam int CMD_IEN_VAL = 3;
	localparam int CMD_TOGGLE = 6;
	localparam int CMD_DONE = 7;
	localparam int CMD_MODE_LSB = 8;
	localparam int CMD_SW_TRIG = 10;
	// latch edge divider
	localparam logic [12:0] LATCH_EDGE_LAST = 13'h1f3f;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		OP_CLEAR = 2'h0,
		OP_VALUE = 2'h1,
		OP_IRQ_EN = 2'h2,
		OP_NONE = 2'h3
	} icc_op_t;
	typedef enum logic [1:0] {
		LM_OFF = 2'h0,
		LM_EVERY = 2'h1,
		LM_DIV = 2'h2,
		LM_SW = 2'h3
	} icc_latch_mode_t;
	typedef enum logic [1:0] {
		XS_IDLE = 2'h1,
		XS_BUSY = 2'h2
	} icc_xfer_state_t;
endpackage

//--- test/icc_cnt_model.sv
// counter logic model answering access starts with a done pulse
`timescale 1ns/100ps
module icc_cnt_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// counter access port
	input wire logic start_in,
	input wire logic slow_in,
	output logic done_out,
	output int starts_out
);
	int wait_r;
	// count down after a start, then pulse done for one cycle
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_r <= 0;
			done_out <= 1'b0;
			starts_out <= 0;
		end else begin
			done_out <= (wait_r == 1);
			if (start_in) begin
				wait_r <= slow_in ? 20 : 1; // prompt or slow answer
				starts_out <= starts_out + 1;
			end else if (wait_r != 0) begin
				wait_r <= wait_r - 1;
			end
		end
	end
endmodule

//--- test/testbench.sv
// self-checking bench for the counter and alarm control block
`timescale 1ns/100ps
module testbench
	import icc_pkg::*;
;
	logic c = 1'b0;
	logic rb = 1'b0;
	logic [15:0] awa = 16'h0000;
	logic [15:0] ara = 16'h0000;
	logic [31:0] wd = 32'h0000_0000;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [3:0] alm = 4'h0;
	logic [7:0] gs = 8'h00, rs = 8'h00;
	logic stb = 1'b0, slow = 1'b0, tog = 1'b0;
	logic awr, wrdy, bv, arr, rv, cst, cdir, cien, lat_o, cdone;
	logic [1:0] bresp, rresp, cop;
	logic [31:0] rdat, r = 32'h87468b92;
	logic [7:0] girq, rirq, tick;
	logic [15:0] v, a;
	int errors = 0, samples_checked = 0, cyc = 0, lat = 0;
	int starts, i, j, n, g;
	// design under test
	icc_ctrl_top dut (.REF_CLK_IN(c), .RST_B_IN(rb),
		.S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
		.S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
		.S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv),
		.S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp),
		.S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
		.S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
		.S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
		.S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
		.S_AXI_RREADY_IN(rr), .OUT_BUS_CLK_LOSS_IN(alm[3]),
		.IN_BUS_CLK_LOSS_IN(alm[2]), .TX_BUS_FIFO_OVFL_IN(alm[1]),
		.TX_CELL_MEM_FULL_IN(alm[0]), .GROUP_OVFL_STATUS_IN(gs),
		.RX_FIFO_OVFL_STATUS_IN(rs), .GROUP_OVFL_IRQ_OUT(girq),
		.RX_FIFO_OVFL_IRQ_OUT(rirq), .INTEG_TICK_OUT(tick),
		.CNT_START_OUT(cst), .CNT_OP_OUT(cop), .CNT_DIR_OUT(cdir),
		.CNT_IEN_VAL_OUT(cien), .CNT_DONE_IN(cdone),
		.COUNTER_LATCH_STROBE_IN(stb), .COUNTER_LATCH_OUT(lat_o));
	// far-side counter logic
	icc_cnt_model model (.clk_in(c), .rst_b_in(rb), .start_in(cst),
		.slow_in(slow), .done_out(cdone), .starts_out(starts));
	// clock, latch pulse tally and hang guard
	always #12.5 c = ~c;
	always @(posedge c) begin
		if (lat_o === 1'b1)
			lat <= lat + 1;
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			errors++;
			finish_test();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] ad(input logic [11:0] x);
		return {2'b00, x, 2'b00};
	endfunction
	function automatic int pd(input logic [3:0] k);
		return 1 << (k + 8);
	endfunction
	// command readback: stored bits, done flag and toggle state
	function automatic logic [15:0] cx(input logic [15:0] x, input logic d);
		return (x & MASK_XFER) | {8'h00, d, tog, 6'h00};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// bus write: release each channel when taken, hold bready to bvalid
	task automatic wc(input logic [15:0] ad_w, input logic [15:0] d,
		input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] rp;
		@(posedge c);
		awa <= ad_w;
		wd <= {16'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge c);
			ta = awv & awr;
			tw = wv & wrdy;
			tb = bv & br;
			rp = bresp;
			@(posedge c);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
			if (tb)
				br <= 1'b0;
		end
		tog = ~tog;
		chk({14'h0000, rp}, {14'h0000, er});
	endtask
	// bus read and compare of data and response
	task automatic rc(input logic [15:0] ad_r, input logic [15:0] e,
		input logic [1:0] er);
		logic ta, tb;
		logic [15:0] d;
		logic [1:0] rp;
		@(posedge c);
		ara <= ad_r;
		arv <= 1'b1;
		rr <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge c);
			ta = arv & arr;
			tb = rv & rr;
			d = rdat[15:0];
			rp = rresp;
			@(posedge c);
			if (ta)
				arv <= 1'b0;
			if (tb)
				rr <= 1'b0;
		end
		chk(d, e);
		chk({14'h0000, rp}, {14'h0000, er});
	endtask
	// tick period between two ticks of one group
	task automatic per(input int gi, input logic [3:0] k);
		int m;
		m = 0;
		@(negedge c);
		while (tick[gi] !== 1'b1 && m < 9000) begin
			@(negedge c);
			m++;
		end
		m = 0;
		do begin
			@(negedge c);
			m++;
		end while (tick[gi] !== 1'b1 && m < 9000);
		chk(16'(m), 16'(pd(k)));
	endtask
	// command write, strobe rises, then latch pulse tally
	task automatic lk(input logic [15:0] x, input int s, input int e);
		int m;
		m = lat;
		wc(ad(IDX_XFER_CMD), x, RESP_OKAY);
		repeat (s) begin
			@(posedge c);
			stb <= 1'b1;
			repeat (2) @(posedge c);
			stb <= 1'b0;
			repeat (2) @(posedge c);
		end
		repeat (6) @(posedge c);
		chk(16'(lat - m), 16'(e));
	endtask
	task automatic finish_test();
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (6) @(posedge c);
		rb <= 1'b1;
		for (i = 0; i < 4; i++)
			rc(ad(IDX_INTEG_FIRST + 12'(i)), RST_INTEG, RESP_OKAY);
		rc(ad(IDX_GRP_IRQ_EN), RST_IRQ_EN, RESP_OKAY);
		rc(ad(IDX_RX_IRQ_EN), RST_IRQ_EN, RESP_OKAY);
		rc(ad(IDX_GEN_STATUS), RST_STATUS, RESP_OKAY);
		rc(ad(IDX_XFER_CMD), RST_XFER, RESP_OKAY);
		rc(16'h1004, 16'h0000, RESP_SLVERR);
		wc(16'h1000, 16'hffff, RESP_SLVERR);
		// integration codes for a random register pair of groups
		r = lfsr(r);
		g = int'(r[1:0]);
		a = ad(IDX_INTEG_FIRST + 12'(g));
		v = {4'hf, 3'h0, r[5], 4'h5, 3'h0, r[4]};
		wc(a, v, RESP_OKAY);
		rc(a, v & 16'h0fff, RESP_OKAY);
		per(g, v[3:0]);
		per(g + 4, v[11:8]);
		wc(a, 16'h000f, RESP_OKAY);
		n = 0;
		repeat (600) begin
			@(negedge c);
			if (tick[g] === 1'b1)
				n++;
		end
		chk(16'(n), 16'h0000);
		// advised codes: E1 on group 0, 24-channel T1 on group 4
		wc(ad(IDX_INTEG_FIRST), 16'h0b0c, RESP_OKAY);
		rc(ad(IDX_INTEG_FIRST), 16'h0b0c, RESP_OKAY);
		// interrupt enables gate rising status bits
		for (j = 0; j < 2; j++) begin
			// bit 0 always enabled and raised so the gated edge is hit
			r = lfsr(r) | 32'h0001_0001;
			a = ad(j ? IDX_RX_IRQ_EN : IDX_GRP_IRQ_EN);
			wc(a, r[15:0], RESP_OKAY);
			rc(a, {8'h00, r[7:0]}, RESP_OKAY);
			@(posedge c);
			if (j)
				rs <= r[23:16];
			else
				gs <= r[23:16];
			@(posedge c);
			@(negedge c);
			chk({8'h00, j ? rirq : girq}, {8'h00, r[7:0] & r[23:16]});
			@(negedge c);
			chk({8'h00, j ? rirq : girq}, 16'h0000);
			@(posedge c);
			gs <= 8'h00;
			rs <= 8'h00;
		end
		// alarm latching and clear by writing zero
		a = ad(IDX_GEN_STATUS);
		for (i = 0; i < 4; i++) begin
			@(posedge c);
			alm[i] <= 1'b1;
			@(posedge c);
			alm <= 4'h0;
			rc(a, 16'((1 << (i + 1)) - 1), RESP_OKAY);
		end
		wc(a, 16'hffff, RESP_OKAY);
		rc(a, 16'h000f, RESP_OKAY);
		wc(a, 16'h000a, RESP_OKAY);
		rc(a, 16'h000a, RESP_OKAY);
		wc(a, 16'h0000, RESP_OKAY);
		rc(a, 16'h0000, RESP_OKAY);
		// counter transfers, every op code, host writes zero to bits 7:4
		a = ad(IDX_XFER_CMD);
		for (i = 0; i < 4; i++) begin
			r = lfsr(r);
			v = {12'h000, r[1], r[0], 2'(i)};
			slow <= (i != 2);
			n = starts;
			wc(a, v, RESP_OKAY);
			if (i < 2)
				rc(a, cx(v, 1'b0), RESP_OKAY);
			repeat (30) @(posedge c);
			rc(a, cx(v, 1'b1), RESP_OKAY);
			chk(16'(starts - n), 16'(i != 3));
			chk({12'h000, cien, cdir, cop}, v);
		end
		// latch source modes with op 11 so no transfer starts
		lk(16'h0103, 3, 3);
		lk(16'h0003, 3, 0);
		lk(16'h0203, 8000, 1);
		lk(16'h0303, 0, 0);
		lk(16'h0703, 0, 1);
		lk(16'h0303, 0, 0);
		finish_test();
	end
endmodule
